// File: design/serial_link_bist_checker.sv
`timescale 1ns/100ps
// What this block does
// - Pin or register bit enters self test
// - Normal range: pixel clock or 33 MHz
// - Register picks 25 MHz without pixel clock
// - Low range: pixel clock or 12.5 MHz
// - Clock-select pin picks self-test clock source
// - Enable high sends back-channel request, wakes remote
// - After lock, pass goes high, checking starts
// - Compare payloads to zero, record mismatches
// - Payload with 1..35 errors pulses pass low
// - Enable low stops; pass shows final result
// - Result held until new test, reset, power-down
// - Enable low returns link to normal
// - Readable link error count of link breaks
// - Readable receive PLL lock status
// - Range mode selects 5-15 or 15-85 MHz
module serial_link_bist_checker #(
	parameter int PAYLOAD_W = bist_pkg::PAYLOAD_W,
	parameter int LINK_ERR_W = bist_pkg::LINK_ERR_W,
	parameter int PAY_ERR_W = bist_pkg::PAY_ERR_W
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic link_clk_in,
	input wire logic [PAYLOAD_W-1:0] payload_in,
	input wire logic payload_valid_in,
	input wire logic rx_lock_in,
	input wire logic self_test_enable_pin_in,
	input wire logic self_test_enable_reg_in,
	input wire logic self_test_clock_select_in,
	input wire logic low_freq_range_in,
	input wire logic osc_25mhz_sel_in,
	input wire logic pclk_present_in,
	input wire logic power_down_in,
	output logic pass_out,
	output logic test_mode_out,
	output logic back_channel_req_out,
	output logic remote_wake_out,
	output logic internal_oscillator_clock_sel_out,
	output logic [bist_pkg::FREQ_W-1:0] osc_freq_khz_out,
	output logic [bist_pkg::FREQ_W-1:0] range_min_khz_out,
	output logic [bist_pkg::FREQ_W-1:0] range_max_khz_out,
	output logic lock_status_out,
	output logic [LINK_ERR_W-1:0] link_error_count_out,
	output logic [PAY_ERR_W-1:0] payload_error_count_out
);

	localparam int BW = $clog2(PAYLOAD_W + 1);
	localparam logic [BW-1:0] ERR_LO = BW'(bist_pkg::ERR_MIN);
	localparam logic [BW-1:0] ERR_HI = BW'(bist_pkg::ERR_MAX);
	localparam logic [LINK_ERR_W-1:0] LINK_MAX = {LINK_ERR_W{1'h1}};
	localparam logic [PAY_ERR_W-1:0] PAY_MAX = {PAY_ERR_W{1'h1}};

	// Count of set bits in a payload
	function automatic logic [BW-1:0] ones(input logic [PAYLOAD_W-1:0] v);
		logic [BW-1:0] n;
		n = '0;
		for (int i = 0; i < PAYLOAD_W; i++) begin
			n = n + BW'(v[i]);
		end
		return n;
	endfunction

	// Reference-domain state
	bist_pkg::bist_state_t state;
	bist_pkg::bist_state_t next_state;
	logic any_error;
	logic en_d;
	logic lock_d;
	logic err_tog_d;
	logic check_en;

	// Pin synchronisers
	logic [3:0] pins_s;
	logic err_tog_s;

	bist_sync2 #(
		.W(4)
	) u_pin_sync (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.d_in({self_test_enable_pin_in, self_test_clock_select_in,
			pclk_present_in, rx_lock_in}),
		.q_out(pins_s)
	);

	wire en_pin_s = pins_s[3];
	wire clk_sel_s = pins_s[2];
	wire pclk_s = pins_s[1];
	wire lock_s = pins_s[0];

	// Link-domain signals
	logic [1:0] link_ctl_s;
	logic err_tog;

	bist_sync2 #(
		.W(2)
	) u_link_sync (
		.clk_in(link_clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(1'h1),
		.d_in({check_en, ce_in}),
		.q_out(link_ctl_s)
	);

	wire check_en_l = link_ctl_s[1];
	wire ce_l = link_ctl_s[0];

	// Payload checker on the recovered clock
	wire [BW-1:0] err_bits = ones(payload_in);
	wire err_in_window = (err_bits >= ERR_LO) && (err_bits <= ERR_HI);
	wire bad_payload = payload_valid_in && check_en_l && err_in_window;

	always_ff @(posedge link_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			err_tog <= 1'h0;
		end else if (ce_l && bad_payload) begin
			err_tog <= ~err_tog;
		end
	end

	a_toggle_on_bad: assert property (
		@(posedge link_clk_in) disable iff (!arst_n_in)
		ce_l && bad_payload |=> err_tog != $past(err_tog)
	) else $error("bad payload not flagged");

	// Error events cross back as a toggle
	bist_sync2 #(
		.W(1)
	) u_err_sync (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.d_in(err_tog),
		.q_out(err_tog_s)
	);

	// Decoding
	wire st_en = en_pin_s | self_test_enable_reg_in;
	wire err_evt = err_tog_s ^ err_tog_d;
	wire in_check = (state == bist_pkg::ST_CHECK);
	wire counted_err = in_check && err_evt;
	wire start = (next_state == bist_pkg::ST_WAIT) && (state != bist_pkg::ST_WAIT);
	wire next_any_error = start ? 1'h0 : (any_error | counted_err);
	wire next_check_en = (next_state == bist_pkg::ST_CHECK);
	wire lock_lost = lock_d && !lock_s;
	wire use_osc = clk_sel_s | !pclk_s;
	wire use_25m = osc_25mhz_sel_in && !pclk_s;

	// Oscillator frequency for the test clock
	wire [bist_pkg::FREQ_W-1:0] next_osc_khz =
		low_freq_range_in ? bist_pkg::OSC_12M5_KHZ :
		use_25m ? bist_pkg::OSC_25M_KHZ :
		bist_pkg::OSC_33M_KHZ;

	// Pixel clock range
	wire [bist_pkg::FREQ_W-1:0] next_min_khz =
		low_freq_range_in ? bist_pkg::LF_MIN_KHZ : bist_pkg::HF_MIN_KHZ;
	wire [bist_pkg::FREQ_W-1:0] next_max_khz =
		low_freq_range_in ? bist_pkg::LF_MAX_KHZ : bist_pkg::HF_MAX_KHZ;

	// Pass level: high while clean, low pulse per bad payload
	wire next_pass =
		(next_state == bist_pkg::ST_CHECK) ? !counted_err :
		(next_state == bist_pkg::ST_DONE) ? !next_any_error :
		1'h0;

	wire [LINK_ERR_W-1:0] next_link_cnt =
		(lock_lost && link_error_count_out != LINK_MAX) ?
		link_error_count_out + 1'h1 : link_error_count_out;

	wire [PAY_ERR_W-1:0] next_pay_cnt =
		start ? '0 :
		(counted_err && payload_error_count_out != PAY_MAX) ?
		payload_error_count_out + 1'h1 : payload_error_count_out;

	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			bist_pkg::ST_IDLE: begin
				if (st_en) begin
					next_state = bist_pkg::ST_WAIT;
				end
			end
			bist_pkg::ST_WAIT: begin
				if (!st_en) begin
					next_state = bist_pkg::ST_DONE;
				end else if (lock_s) begin
					next_state = bist_pkg::ST_CHECK;
				end
			end
			bist_pkg::ST_CHECK: begin
				if (!st_en) begin
					next_state = bist_pkg::ST_DONE;
				end
			end
			bist_pkg::ST_DONE: begin
				if (st_en) begin
					next_state = bist_pkg::ST_WAIT;
				end
			end
			default: begin
				next_state = bist_pkg::ST_IDLE;
			end
		endcase
		if (power_down_in) begin
			next_state = bist_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= bist_pkg::ST_IDLE;
			any_error <= 1'h0;
			check_en <= 1'h0;
			pass_out <= 1'h0;
		end else if (ce_in) begin
			state <= next_state;
			any_error <= next_any_error;
			check_en <= next_check_en;
			pass_out <= next_pass;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			en_d <= 1'h0;
			test_mode_out <= 1'h0;
			back_channel_req_out <= 1'h0;
			remote_wake_out <= 1'h0;
		end else if (ce_in) begin
			en_d <= st_en;
			test_mode_out <= st_en;
			back_channel_req_out <= st_en;
			remote_wake_out <= st_en && !en_d;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			internal_oscillator_clock_sel_out <= 1'h0;
			osc_freq_khz_out <= bist_pkg::OSC_33M_KHZ;
			range_min_khz_out <= bist_pkg::HF_MIN_KHZ;
			range_max_khz_out <= bist_pkg::HF_MAX_KHZ;
		end else if (ce_in) begin
			internal_oscillator_clock_sel_out <= use_osc;
			osc_freq_khz_out <= next_osc_khz;
			range_min_khz_out <= next_min_khz;
			range_max_khz_out <= next_max_khz;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lock_d <= 1'h0;
			err_tog_d <= 1'h0;
			lock_status_out <= 1'h0;
			link_error_count_out <= '0;
			payload_error_count_out <= '0;
		end else if (ce_in) begin
			lock_d <= lock_s;
			err_tog_d <= err_tog_s;
			lock_status_out <= lock_s;
			link_error_count_out <= next_link_cnt;
			payload_error_count_out <= next_pay_cnt;
		end
	end

	a_enter_test: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		ce_in && self_test_enable_reg_in && !power_down_in &&
		state == bist_pkg::ST_IDLE |=> state == bist_pkg::ST_WAIT
	) else $error("enable did not start test");

	a_request_sent: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		ce_in && st_en && !en_d |=> back_channel_req_out && remote_wake_out
	) else $error("back-channel request missing");

	a_lock_pass_high: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		ce_in && state == bist_pkg::ST_WAIT && st_en && lock_s &&
		!power_down_in |=> pass_out && state == bist_pkg::ST_CHECK
	) else $error("pass not high after lock");

	a_error_pulse_low: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		ce_in && counted_err && st_en && !power_down_in &&
		payload_error_count_out != PAY_MAX
		|=> !pass_out && payload_error_count_out != $past(payload_error_count_out)
	) else $error("error payload not pulsed");

	a_final_fail: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		ce_in && in_check && !st_en && (any_error || err_evt) &&
		!power_down_in |=> !pass_out && state == bist_pkg::ST_DONE
	) else $error("failed run shows pass");

	a_final_pass: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		ce_in && in_check && !st_en && !any_error && !err_evt &&
		!power_down_in |=> pass_out
	) else $error("clean run shows fail");

	a_hold_result: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		state == bist_pkg::ST_DONE && !st_en && !power_down_in
		|=> $stable(pass_out)
	) else $error("result not held");

	a_wait_quiet: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		state == bist_pkg::ST_WAIT |-> !pass_out && !check_en
	) else $error("flagging before lock");

	a_link_break_count: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		ce_in && lock_lost && link_error_count_out != LINK_MAX
		|=> link_error_count_out == LINK_ERR_W'($past(link_error_count_out) + 1'h1)
	) else $error("link break not counted");

	a_low_range_osc: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		ce_in && low_freq_range_in
		|=> osc_freq_khz_out == bist_pkg::OSC_12M5_KHZ &&
		range_max_khz_out == bist_pkg::LF_MAX_KHZ
	) else $error("low range oscillator wrong");

	a_normal_after: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		ce_in && !st_en |=> !test_mode_out && !back_channel_req_out
	) else $error("link not back to normal");

endmodule

// File: design/bist_pkg.sv
package bist_pkg;

	// Payload shape and error window
	localparam int PAYLOAD_W = 36;
	localparam int ERR_MIN = 1;
	localparam int ERR_MAX = 35;

	// Counter widths
	localparam int LINK_ERR_W = 8;
	localparam int PAY_ERR_W = 16;

	// Frequencies in kHz
	localparam int FREQ_W = 17;
	localparam logic [FREQ_W-1:0] OSC_33M_KHZ = 17'h080E8;
	localparam logic [FREQ_W-1:0] OSC_25M_KHZ = 17'h061A8;
	localparam logic [FREQ_W-1:0] OSC_12M5_KHZ = 17'h030D4;
	localparam logic [FREQ_W-1:0] LF_MIN_KHZ = 17'h01388;
	localparam logic [FREQ_W-1:0] LF_MAX_KHZ = 17'h03A98;
	localparam logic [FREQ_W-1:0] HF_MIN_KHZ = 17'h03A98;
	localparam logic [FREQ_W-1:0] HF_MAX_KHZ = 17'h14C08;

	// Synchroniser reset value
	localparam logic SYNC_RST = 1'h0;

	// Self-test sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_CHECK = 4'h4,
		ST_DONE = 4'h8
	} bist_state_t;

endpackage

// File: design/bist_sync2.sv
`timescale 1ns/100ps
module bist_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);

	logic [W-1:0] meta;

	// Two-stage synchroniser, first stage feeds only the second
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta <= {W{bist_pkg::SYNC_RST}};
			q_out <= {W{bist_pkg::SYNC_RST}};
		end else if (ce_in) begin
			meta <= d_in;
			q_out <= meta;
		end
	end

endmodule

// File: sim/remote_tx_model.sv
`timescale 1ns/100ps
module remote_tx_model (
	input wire logic link_clk_in,
	input wire logic arst_n_in,
	input wire logic req_in,
	input wire logic inj_tog_in,
	input wire logic [35:0] err_pat_in,
	output logic lock_out,
	output logic valid_out,
	output logic [35:0] payload_out,
	output logic [7:0] crc_count_out
);
	logic [1:0] req_s;
	logic [3:0] lock_cnt;
	logic inj_seen;
	always_ff @(posedge link_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			req_s <= 2'h0;
			lock_cnt <= 4'h0;
			inj_seen <= 1'h0;
			crc_count_out <= 8'h00;
			lock_out <= 1'h0;
			valid_out <= 1'h0;
			payload_out <= 36'h0;
		end else begin
			req_s <= {req_s[0], req_in};
			inj_seen <= inj_tog_in;
			lock_cnt <= !req_s[1] ? 4'h0 : (lock_cnt == 4'hF) ? lock_cnt : lock_cnt + 4'h1;
			lock_out <= req_s[1] && lock_cnt >= 4'h8;
			valid_out <= req_s[1];
			if (req_s[1] && inj_seen != inj_tog_in)
				payload_out <= err_pat_in;
			else if (req_s[1])
				payload_out <= 36'h0;
			else
				payload_out <= ~payload_out;
			// Injected errors in lock stand for back-channel CRC errors
			if (req_s[0] && !req_s[1])
				crc_count_out <= 8'h00;
			else if (req_s[1] && lock_out && inj_seen != inj_tog_in && crc_count_out != 8'hFF)
				crc_count_out <= crc_count_out + 8'h01;
		end
	end
endmodule

// File: sim/test_serial_link_bist_checker.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_serial_link_bist_checker;
	logic clk = 0, rst_n = 0, lclk = 0, pin = 0, regb = 0, csel = 0, lfr = 0, o25 = 0;
	logic pclk = 1, pd = 0, inj = 0, prev = 0, ce = 1;
	logic [35:0] pat = 36'h0, pay;
	logic [31:0] seed = 32'h430EAB99;
	logic valid, lock, pass, tmode, req, wake, osel, lstat;
	logic [16:0] fq, rmin, rmax;
	logic [7:0] lerr, crc;
	logic [15:0] perr;
	int num_errors = 0, check_count = 0, lows = 0, wakes = 0, k;
	always #25 clk = ~clk;
	initial #13 forever #80 lclk = ~lclk;
	serial_link_bist_checker i_dut (.ref_clk_in(clk), .arst_n_in(rst_n), .ce_in(ce),
		.link_clk_in(lclk), .payload_in(pay), .payload_valid_in(valid), .rx_lock_in(lock),
		.self_test_enable_pin_in(pin), .self_test_enable_reg_in(regb),
		.self_test_clock_select_in(csel), .low_freq_range_in(lfr), .osc_25mhz_sel_in(o25),
		.pclk_present_in(pclk), .power_down_in(pd), .pass_out(pass), .test_mode_out(tmode),
		.back_channel_req_out(req), .remote_wake_out(wake),
		.internal_oscillator_clock_sel_out(osel), .osc_freq_khz_out(fq),
		.range_min_khz_out(rmin), .range_max_khz_out(rmax), .lock_status_out(lstat),
		.link_error_count_out(lerr), .payload_error_count_out(perr));
	remote_tx_model i_far (.link_clk_in(lclk), .arst_n_in(rst_n), .req_in(req),
		.inj_tog_in(inj), .err_pat_in(pat), .lock_out(lock), .valid_out(valid),
		.payload_out(pay), .crc_count_out(crc));
	always @(negedge clk) begin
		if (pass === 1'b0 && prev === 1'b1 && tmode === 1'b1)
			lows++;
		prev = pass;
		if (wake === 1'b1)
			wakes++;
	end
	function logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function int is_bad(input logic [35:0] p);
		return ($countones(p) >= 1 && $countones(p) <= 35) ? 1 : 0;
	endfunction
	function logic [35:0] mk(input int n, input int s);
		logic [35:0] m;
		m = {36{1'b1}} >> (36 - n);
		return (m << s) | (m >> (36 - s));
	endfunction
	function logic [16:0] exp_osc(input logic l, input logic o, input logic p);
		return l ? bist_pkg::OSC_12M5_KHZ :
			(o && !p) ? bist_pkg::OSC_25M_KHZ : bist_pkg::OSC_33M_KHZ;
	endfunction
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wait_pass(input logic v);
		int i;
		i = 0;
		@(negedge clk);
		while (pass !== v && i < 400) begin
			@(negedge clk);
			i++;
		end
	endtask
	task run(input logic use_pin, input int n);
		int bad, i, c;
		bad = 0;
		@(posedge clk);
		if (use_pin)
			pin <= 1'b1;
		else
			regb <= 1'b1;
		cyc(12);
		@(negedge clk);
		`CHK(pass, 1'h0)
		`CHK(tmode, 1'h1)
		@(posedge clk);
		pat <= {1'h0, {35{1'h1}}};
		inj <= ~inj;
		wait_pass(1'b1);
		`CHK(pass, 1'b1)
		`CHK(tmode, 1'b1)
		`CHK(req, 1'b1)
		`CHK(lstat, 1'b1)
		lows = 0;
		for (i = 0; i < n; i++) begin
			seed = xs(seed);
			c = (i == 0) ? 1 : (i == 1) ? 35 : (i == 2) ? 36 : 1 + int'(seed % 35);
			@(posedge clk);
			pat <= mk(c, int'(seed[15:0] % 36));
			bad += is_bad(mk(c, int'(seed[15:0] % 36)));
			@(posedge clk);
			inj <= ~inj;
			cyc(30);
		end
		@(negedge clk);
		`CHK(lows, bad)
		`CHK(perr, 16'(bad))
		@(posedge clk);
		pin <= 1'b0;
		regb <= 1'b0;
		cyc(6);
		@(negedge clk);
		`CHK(tmode, 1'b0)
		`CHK(pass, (bad == 0) ? 1'b1 : 1'b0)
		cyc(40);
		@(negedge clk);
		`CHK(pass, (bad == 0) ? 1'b1 : 1'b0)
		`CHK(crc, 8'(n))
	endtask
	task print_verdict;
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#1000000;
		num_errors++;
		print_verdict;
	end
	initial begin
		cyc(8);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK(pass, 1'b0)
		`CHK(fq, bist_pkg::OSC_33M_KHZ)
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			{csel, lfr, o25, pclk} <= 4'(k);
			cyc(6);
			@(negedge clk);
			`CHK(osel, csel | ~pclk)
			`CHK(fq, exp_osc(lfr, o25, pclk))
			`CHK(rmin, lfr ? bist_pkg::LF_MIN_KHZ : bist_pkg::HF_MIN_KHZ)
			`CHK(rmax, lfr ? bist_pkg::LF_MAX_KHZ : bist_pkg::HF_MAX_KHZ)
		end
		run(1'b0, 0);
		run(1'b1, 8);
		run(1'b0, 0);
		@(posedge clk);
		ce <= 1'h0;
		regb <= 1'h1;
		cyc(4);
		@(negedge clk);
		`CHK(tmode, 1'h0)
		`CHK(pass, 1'h1)
		@(posedge clk);
		ce <= 1'h1;
		regb <= 1'h0;
		@(posedge clk);
		pd <= 1'b1;
		cyc(3);
		@(negedge clk);
		`CHK(pass, 1'b0)
		`CHK(wakes, 3)
		`CHK(lerr, 8'h03)
		`CHK(lstat, 1'b0)
		print_verdict;
	end
endmodule
